// ---- bench/dtc_host_model.sv ----
// Host controller model driving the device command and crc error inputs
`timescale 1ns/10ps

module dtc_host_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire dtc_pkg::dtc_cmd_t req_cmd_in,
  input wire logic crc_in,
  output logic accept_out,
  output logic cmd_valid_out,
  output dtc_pkg::dtc_cmd_t cmd_out,
  output logic crc_err_out
);
  import dtc_pkg::*;

  localparam int REF_GAP_CYC = (350 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Hold after reset exit with clock enable high, before any mode-register command
  localparam int INIT_HOLD_CYC = 16;
  localparam int MRS_GAP_CYC = 5;
  int gap;
  int init_cnt;
  int mrs_cnt;

  // Activate and refresh held back until the refresh period has run out
  assign accept_out = req_in && !(gap != 0 && (req_cmd_in == CMD_ACT || req_cmd_in == CMD_REF))
    && !(init_cnt != 0 && req_cmd_in == CMD_MRS_PDA)
    && !(mrs_cnt != 0 && req_cmd_in != CMD_MRS_PDA);

  // Start-up hold and spacing after a mode-register command
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      init_cnt <= INIT_HOLD_CYC;
      mrs_cnt <= 0;
    end
    else
    begin
      init_cnt <= (init_cnt != 0) ? init_cnt - 1 : 0;
      if (accept_out && req_cmd_in == CMD_MRS_PDA)
      begin
        mrs_cnt <= MRS_GAP_CYC - 1;
      end
      else
      begin
        mrs_cnt <= (mrs_cnt != 0) ? mrs_cnt - 1 : 0;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      gap <= 0;
      cmd_valid_out <= 1'b0;
      cmd_out <= CMD_NOP;
    end
    else if (accept_out)
    begin
      cmd_valid_out <= 1'b1;
      cmd_out <= req_cmd_in;
      gap <= (req_cmd_in == CMD_REF) ? REF_GAP_CYC - 1 : ((gap != 0) ? gap - 1 : 0);
    end
    else
    begin
      cmd_valid_out <= 1'b0;
      // Idle command lines keep moving
      cmd_out <= dtc_cmd_t'(~3'(cmd_out));
      gap <= (gap != 0) ? gap - 1 : 0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    crc_err_out <= rst_in ? 1'b0 : crc_in;
  end

endmodule : dtc_host_model

// ---- bench/tb_top.sv ----
// Self-checking testbench of the device timing block
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end

module tb_top;
  import dtc_pkg::*;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cke = 1'b1, dq0 = 1'b1, req = 1'b0, crc = 1'b0, accept;
  dtc_cmd_t req_cmd = CMD_NOP;
  logic cmd_valid, crc_err, alert_n, iws, dqs_oe, pd, pda;
  dtc_cmd_t cmd;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] q;
  logic e;
  int wl, rl, bc4, pre;
  logic [31:0] sd;

  always #12.5 clk_in = ~clk_in;

  dtc_timing_top u_dtc_timing_top (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cke_in(cke),
    .dq0_in(dq0), .cmd_valid_in(cmd_valid), .cmd_in(cmd), .crc_err_in(crc_err),
    .alert_n_out(alert_n), .int_write_start_out(iws), .dqs_oe_out(dqs_oe),
    .power_down_out(pd), .pda_mode_out(pda));

  dtc_host_model u_dtc_host_model (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .req_cmd_in(req_cmd), .crc_in(crc), .accept_out(accept), .cmd_valid_out(cmd_valid),
    .cmd_out(cmd), .crc_err_out(crc_err));

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle

  task automatic send(input dtc_cmd_t c);
    @(posedge clk_in);
    req <= 1'b1;
    req_cmd <= c;
    do @(posedge clk_in); while (accept !== 1'b1);
    req <= 1'b0;
  endtask : send

  function automatic logic pick(input int s);
    case (s)
      0: pick = ~alert_n;
      1: pick = iws;
      default: pick = dqs_oe;
    endcase
  endfunction : pick

  // Times start and width of an output pulse from the stimulus cycle
  task automatic timed(input int s, input int exp_start, input int exp_width);
    int n, st, w;
    n = 0;
    st = -1;
    w = 0;
    @(negedge clk_in);
    while (cmd_valid !== 1'b1 && crc_err !== 1'b1 && n++ < 50) @(negedge clk_in);
    for (n = 0; n < 60; n++)
    begin
      if (pick(s) === 1'b1)
      begin
        if (st < 0)
          st = n;
        w++;
      end
      @(negedge clk_in);
    end
    `CHK(st, exp_start)
    `CHK(w, exp_width)
  endtask : timed

  initial
  begin
    void'($urandom(32'h7284));
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(q, 32'h00110900)
    `CHK(pd, 1'b0)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b0, 12'h008, 32'h0);
    `CHK({e, q}, 33'h100000000)
    apb(1'b1, STATUS_OFS, 32'hffffffff);
    `CHK(e, 1'b1)
    // Single crc error, then two back to back inside one pulse
    crc <= 1'b1;
    @(posedge clk_in);
    crc <= 1'b0;
    timed(0, 1, 8);
    @(posedge clk_in);
    fork
      begin
        crc <= 1'b1;
        idle(2);
        crc <= 1'b0;
      end
      timed(0, 1, 8);
    join
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[15:8], 8'h03)
    // Write start over random write latencies, both burst modes
    for (int i = 0; i < 6; i++)
    begin
      wl = (i == 0) ? 20 : 5 + $urandom % 16;
      bc4 = (i < 2) ? i : $urandom % 2;
      apb(1'b1, CTRL_OFS, (32'h11 << 16) | (wl << 8) | (bc4 << 2));
      send(CMD_WR);
      timed(1, wl + (bc4 ? 2 : 4), 1);
    end
    // Read strobe enable for both preamble lengths
    for (pre = 1; pre <= 2; pre++)
    begin
      rl = 8 + $urandom % 13;
      apb(1'b1, CTRL_OFS, (rl << 16) | 32'h0900 | 32'h8 | (pre - 1));
      send(CMD_RD);
      timed(2, rl - pre + 1, pre + 4);
    end
    apb(1'b1, CTRL_OFS, 32'h00110a0b);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(q, 32'h00110a0b)
    apb(1'b1, CTRL_OFS, 32'h00110903);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(q, 32'h00110900)
    // Per-device addressing: reference trained, data bit level
    sd = {8'h0, 8'h10, 8'h00, 8'h10};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, CTRL_OFS, 32'h00110900 | sd[8*i +: 8]);
      dq0 <= (i >= 2);
      idle(4);
      send(CMD_MRS_PDA);
      idle(2);
      `CHK(pda, (i == 0))
    end
    // Clock enable dropped while refresh still runs
    send(CMD_REF);
    cke <= 1'b0;
    idle(5);
    `CHK(pd, 1'b0)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[4:3], 2'h3)
    idle(20);
    `CHK(pd, 1'b1)
    send(CMD_ACT);
    idle(2);
    cke <= 1'b1;
    idle(6);
    `CHK(pd, 1'b0)
    final_report();
  end

endmodule : tb_top

// ---- core/dtc_alert_gen.sv ----
// Write CRC error alert pulse generator
`timescale 1ns/10ps

module dtc_alert_gen (
  input wire logic clk_in,
  input wire logic rst_in,
  dtc_alert_if.gen al
);
  import dtc_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] run_reg;

  // Errors during a pulse do not stretch it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= 4'h0;
    end
    else if (al.err && cnt_reg == 4'h0)
    begin
      cnt_reg <= ALERT_PW_CYC;
    end
    else if (cnt_reg != 4'h0)
    begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  assign al.active = (cnt_reg != 4'h0);
  assign al.dropped = al.err && (cnt_reg != 4'h0);

  // Length of the current pulse, for checking
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      run_reg <= 4'h0;
    end
    else if (al.active)
    begin
      run_reg <= run_reg + 4'h1;
    end
    else
    begin
      run_reg <= 4'h0;
    end
  end

  a_alert_latency: assert property (@(posedge clk_in) disable iff (rst_in)
    al.err && !al.active |=> al.active)
    else $error("alert not raised one cycle after crc error");

  a_alert_width: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(al.active) |-> (run_reg >= 4'(ALERT_PW_MIN_CYC)) && (run_reg <= 4'(ALERT_PW_MAX_CYC)))
    else $error("alert pulse width outside 6 to 10 clocks");

  a_alert_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(al.active) |-> al.active [*6])
    else $error("alert pulse shorter than 6 clocks");

  c_alert_pulse: cover property (@(posedge clk_in) disable iff (rst_in)
    $fell(al.active));

  c_alert_dropped: cover property (@(posedge clk_in) disable iff (rst_in)
    al.dropped);

endmodule : dtc_alert_gen

// ---- core/dtc_delay_line.sv ----
// Shift-register delay line: one pulse per command, delay chosen per command
`timescale 1ns/10ps

module dtc_delay_line (
  input wire logic clk_in,
  input wire logic rst_in,
  dtc_dly_if.dly dl
);
  import dtc_pkg::*;

  logic [DLY_W-1:0] sr_reg;
  logic [DLY_W-1:0] sr_next;

  // Overlapping commands each keep their own slot
  always_comb
  begin
    sr_next = sr_reg >> 1;
    if (dl.cmd)
    begin
      sr_next = sr_next | dtc_onehot(dl.delay);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sr_reg <= '0;
    end
    else
    begin
      sr_reg <= sr_next;
    end
  end

  assign dl.pulse = sr_reg[0];

endmodule : dtc_delay_line

// ---- core/dtc_if.sv ----
// Interfaces between the timing block top and its delay line and alert generator
`timescale 1ns/10ps

interface dtc_dly_if;
  logic cmd;
  logic [5:0] delay;
  logic pulse;
  modport src (output cmd, output delay, input pulse);
  modport dly (input cmd, input delay, output pulse);
endinterface : dtc_dly_if

interface dtc_alert_if;
  logic err;
  logic active;
  logic dropped;
  modport src (output err, input active, input dropped);
  modport gen (input err, output active, output dropped);
endinterface : dtc_alert_if

// ---- core/dtc_pkg.sv ----
// Package: constants, types and helpers of the DDR4 device timing block
package dtc_pkg;

  // Clock
  localparam int CLK_PERIOD_PS = 25000;

  // Write CRC error alert
  localparam int CRC_ALERT_MIN_NS = 3;
  localparam int CRC_ALERT_MAX_NS = 13;
  localparam int ALERT_LAT_MIN_CYC = (CRC_ALERT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ALERT_LAT_MAX_RAW = (CRC_ALERT_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int ALERT_LAT_MAX_CYC = (ALERT_LAT_MAX_RAW < 1) ? 1 : ALERT_LAT_MAX_RAW;
  localparam int ALERT_PW_MIN_CYC = 6;
  localparam int ALERT_PW_MAX_CYC = 10;
  localparam logic [3:0] ALERT_PW_CYC = 4'h8;

  // Internal write start after write latency
  localparam logic [5:0] WR_START_FULL_CYC = 6'h04;
  localparam logic [5:0] WR_START_BC4_CYC = 6'h02;

  // Read strobe preamble lengths and burst length in clocks
  localparam logic [5:0] RD_PRE_1T_CYC = 6'h01;
  localparam logic [5:0] RD_PRE_2T_CYC = 6'h02;
  localparam logic [2:0] BURST_CYC = 3'h4;

  // Row and refresh operations in progress
  localparam int TRFC1_NS = 350;
  localparam logic [4:0] REF_BUSY_CYC = 5'((TRFC1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [4:0] ROW_BUSY_CYC = 5'h04;

  // Register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;

  // Control fields
  localparam int CTRL_RD_PRE_BIT = 0;
  localparam int CTRL_WR_PRE_BIT = 1;
  localparam int CTRL_BC4_BIT = 2;
  localparam int CTRL_RATE_BIT = 3;
  localparam int CTRL_VREF_BIT = 4;
  localparam int CTRL_WL_LSB = 8;
  localparam int CTRL_RL_LSB = 16;
  localparam logic [4:0] WL_RST = 5'h09;
  localparam logic [4:0] RL_RST = 5'h11;

  // Status fields
  localparam int STAT_ALERT_BIT = 0;
  localparam int STAT_PDA_BIT = 1;
  localparam int STAT_PD_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_CKE_LOW_BIT = 4;
  localparam int STAT_CRC_CNT_LSB = 8;

  // Delay line length
  localparam int DLY_W = 32;
  localparam logic [5:0] AGE_MAX = 6'h3f;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_PRE = 3'h2,
    CMD_REF = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_MRS_PDA = 3'h6
  } dtc_cmd_t;

  // One-hot slot for a delay of d cycles, zero treated as one
  function automatic logic [DLY_W-1:0] dtc_onehot(input logic [5:0] d);
    logic [5:0] idx;
    idx = (d == 6'h00) ? 6'h00 : d - 6'h01;
    dtc_onehot = {{(DLY_W-1){1'b0}}, 1'b1} << idx[4:0];
  endfunction : dtc_onehot

endpackage : dtc_pkg

// ---- core/dtc_timing_top.sv ----
// Device-side timing logic: crc alert, write start, read preamble, power-down, pda
`timescale 1ns/10ps

module dtc_timing_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cke_in,
  input wire logic dq0_in,
  input wire logic cmd_valid_in,
  input wire dtc_pkg::dtc_cmd_t cmd_in,
  input wire logic crc_err_in,
  output logic alert_n_out,
  output logic int_write_start_out,
  output logic dqs_oe_out,
  output logic power_down_out,
  output logic pda_mode_out
);
  import dtc_pkg::*;

  logic rd_pre_2t_reg;
  logic wr_pre_2t_reg;
  logic bc4_fixed_reg;
  logic rate_fast_reg;
  logic vref_trained_reg;
  logic [4:0] wl_reg;
  logic [4:0] rl_reg;
  logic [31:0] prdata_reg;
  logic [7:0] crc_cnt_reg;
  logic cke_s1_reg;
  logic cke_s2_reg;
  logic dq0_s1_reg;
  logic dq0_s2_reg;
  logic [4:0] busy_cnt_reg;
  logic pd_reg;
  logic pda_reg;
  logic [2:0] oe_cnt_reg;
  logic [5:0] wr_age_reg;
  logic [5:0] rd_age_reg;
  logic wr_single_reg;
  logic rd_single_reg;
  logic addr_ok;
  logic wr_en;
  logic wr_cmd;
  logic rd_cmd;
  logic pda_cmd;
  logic [5:0] wr_dly;
  logic [5:0] rd_pre;
  logic [5:0] rd_dly;
  logic [31:0] ctrl_val;
  logic [31:0] stat_val;

  dtc_dly_if wr_dl ();
  dtc_dly_if rd_dl ();
  dtc_alert_if alert ();

  dtc_delay_line u_wr_line (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .dl (wr_dl.dly)
  );

  dtc_delay_line u_rd_line (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .dl (rd_dl.dly)
  );

  dtc_alert_gen u_alert (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .al (alert.gen)
  );

  // APB decode, zero wait states
  assign addr_ok = (paddr_in == CTRL_OFS) || (paddr_in == STATUS_OFS);
  assign wr_en = psel_in && penable_in && pwrite_in && (paddr_in == CTRL_OFS);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && (!addr_ok || (pwrite_in && paddr_in != CTRL_OFS));
  assign prdata_out = prdata_reg;

  assign ctrl_val = {11'h000, rl_reg, 3'h0, wl_reg, 3'h0, vref_trained_reg, rate_fast_reg,
                     bc4_fixed_reg, wr_pre_2t_reg, rd_pre_2t_reg};
  assign stat_val = {16'h0000, crc_cnt_reg, 3'h0, !cke_s2_reg, (busy_cnt_reg != 5'h00),
                     pd_reg, pda_reg, alert.active};

  // Read data captured in the setup phase
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (psel_in && !penable_in && !pwrite_in)
    begin
      prdata_reg <= (paddr_in == CTRL_OFS) ? ctrl_val :
                    (paddr_in == STATUS_OFS) ? stat_val : 32'h0000_0000;
    end
  end

  // Control register; two-clock preambles only when the fast-rate bit is set
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_pre_2t_reg <= 1'b0;
      wr_pre_2t_reg <= 1'b0;
      bc4_fixed_reg <= 1'b0;
      rate_fast_reg <= 1'b0;
      vref_trained_reg <= 1'b0;
      wl_reg <= WL_RST;
      rl_reg <= RL_RST;
    end
    else if (wr_en)
    begin
      rd_pre_2t_reg <= pwdata_in[CTRL_RD_PRE_BIT] && pwdata_in[CTRL_RATE_BIT];
      wr_pre_2t_reg <= pwdata_in[CTRL_WR_PRE_BIT] && pwdata_in[CTRL_RATE_BIT];
      bc4_fixed_reg <= pwdata_in[CTRL_BC4_BIT];
      rate_fast_reg <= pwdata_in[CTRL_RATE_BIT];
      vref_trained_reg <= pwdata_in[CTRL_VREF_BIT];
      wl_reg <= pwdata_in[CTRL_WL_LSB +: 5];
      rl_reg <= pwdata_in[CTRL_RL_LSB +: 5];
    end
  end

  // Pin synchronisers; clock enable resets high so reset exit shows no false power-down
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cke_s1_reg <= 1'b1;
      cke_s2_reg <= 1'b1;
      dq0_s1_reg <= 1'b1;
      dq0_s2_reg <= 1'b1;
    end
    else
    begin
      cke_s1_reg <= cke_in;
      cke_s2_reg <= cke_s1_reg;
      dq0_s1_reg <= dq0_in;
      dq0_s2_reg <= dq0_s1_reg;
    end
  end

  assign wr_cmd = cmd_valid_in && (cmd_in == CMD_WR);
  assign rd_cmd = cmd_valid_in && (cmd_in == CMD_RD);
  assign pda_cmd = cmd_valid_in && (cmd_in == CMD_MRS_PDA);

  // Crc alert and error count
  assign alert.err = crc_err_in;
  assign alert_n_out = !alert.active;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      crc_cnt_reg <= 8'h00;
    end
    else if (crc_err_in && crc_cnt_reg != 8'hff)
    begin
      crc_cnt_reg <= crc_cnt_reg + 8'h01;
    end
  end

  // Internal write start
  assign wr_dly = {1'b0, wl_reg} + (bc4_fixed_reg ? WR_START_BC4_CYC : WR_START_FULL_CYC);
  assign wr_dl.cmd = wr_cmd;
  assign wr_dl.delay = wr_dly;
  assign int_write_start_out = wr_dl.pulse;

  // Read strobe leaves high impedance one cycle earlier in two-clock mode
  assign rd_pre = rd_pre_2t_reg ? RD_PRE_2T_CYC : RD_PRE_1T_CYC;
  assign rd_dly = {1'b0, rl_reg} - rd_pre;
  assign rd_dl.cmd = rd_cmd;
  assign rd_dl.delay = rd_dly;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      oe_cnt_reg <= 3'h0;
    end
    else if (rd_dl.pulse)
    begin
      oe_cnt_reg <= rd_pre[2:0] + BURST_CYC;
    end
    else if (oe_cnt_reg != 3'h0)
    begin
      oe_cnt_reg <= oe_cnt_reg - 3'h1;
    end
  end

  assign dqs_oe_out = (oe_cnt_reg != 3'h0);

  // Row and refresh operations still in progress
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      busy_cnt_reg <= 5'h00;
    end
    else if (cmd_valid_in && cmd_in == CMD_REF)
    begin
      busy_cnt_reg <= REF_BUSY_CYC;
    end
    else if (cmd_valid_in && (cmd_in == CMD_ACT || cmd_in == CMD_PRE))
    begin
      busy_cnt_reg <= (busy_cnt_reg > ROW_BUSY_CYC) ? busy_cnt_reg : ROW_BUSY_CYC;
    end
    else if (busy_cnt_reg != 5'h00)
    begin
      busy_cnt_reg <= busy_cnt_reg - 5'h01;
    end
  end

  // Cke high is taken at once; power-down waits for the operations to finish
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pd_reg <= 1'b0;
    end
    else if (cke_s2_reg)
    begin
      pd_reg <= 1'b0;
    end
    else if (busy_cnt_reg == 5'h00)
    begin
      pd_reg <= 1'b1;
    end
  end

  assign power_down_out = pd_reg;

  // Per-device addressing: low on the lowest data bit enters, trained reference only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pda_reg <= 1'b0;
    end
    else if (pda_cmd)
    begin
      pda_reg <= vref_trained_reg && !dq0_s2_reg;
    end
  end

  assign pda_mode_out = pda_reg;

  // Cycles since the last write and read, for checking
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_age_reg <= AGE_MAX;
      rd_age_reg <= AGE_MAX;
      wr_single_reg <= 1'b0;
      rd_single_reg <= 1'b0;
    end
    else
    begin
      wr_age_reg <= wr_cmd ? 6'h00 : (wr_age_reg == AGE_MAX) ? AGE_MAX : wr_age_reg + 6'h01;
      rd_age_reg <= rd_cmd ? 6'h00 : (rd_age_reg == AGE_MAX) ? AGE_MAX : rd_age_reg + 6'h01;
      if (wr_cmd)
      begin
        wr_single_reg <= (wr_age_reg == AGE_MAX);
      end
      if (rd_cmd)
      begin
        rd_single_reg <= (rd_age_reg == AGE_MAX);
      end
    end
  end

  a_write_start_delay: assert property (@(posedge clk_in) disable iff (rst_in)
    int_write_start_out && wr_single_reg |-> wr_age_reg == wr_dly - 6'h01)
    else $error("internal write start not at write latency plus 4 or 2");

  a_read_preamble_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(dqs_oe_out) && rd_single_reg |-> rd_age_reg == rd_dly)
    else $error("read strobe drive start not matched to preamble mode");

  a_pd_waits_ops: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(pd_reg) |-> $past(busy_cnt_reg) == 5'h00 && !$past(cke_s2_reg))
    else $error("power-down entered while operations in progress");

  a_rd_pre_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_pre_2t_reg |-> rate_fast_reg)
    else $error("two-clock read preamble without fast rate");

  a_wr_pre_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_en |=> wr_pre_2t_reg == ($past(pwdata_in[CTRL_WR_PRE_BIT]) && rate_fast_reg))
    else $error("write preamble mode not set as written");

  a_pda_entry: assert property (@(posedge clk_in) disable iff (rst_in)
    pda_cmd |=> pda_reg == ($past(vref_trained_reg) && !$past(dq0_s2_reg)))
    else $error("pda mode not decided by lowest data bit");

  c_pda_entry: cover property (@(posedge clk_in) disable iff (rst_in) $rose(pda_reg));
  c_power_down: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(pd_reg) && $past(busy_cnt_reg, 2) != 5'h00);
  c_rd_2t: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(dqs_oe_out) && rd_pre_2t_reg);

endmodule : dtc_timing_top
